// *** inc/drm_alarm_map.vh ***
`ifndef DRM_ALARM_MAP_VH
`define DRM_ALARM_MAP_VH

// register byte offsets (low byte; high byte at offset + 1)
`define DRM_OFS_THR_ONE 7'h10
`define DRM_OFS_THR_TWO 7'h12
`define DRM_OFS_WIN_ONE 7'h14
`define DRM_OFS_WIN_TWO 7'h16
`define DRM_OFS_CFG 7'h18
`define DRM_OFS_DIAG 7'h26

// reset values
`define DRM_RST_THR 16'h0000
`define DRM_RST_WIN 8'h00
`define DRM_RST_CFG 16'h0000

// alarm_config fields
`define DRM_CFG_SRC_TWO_MSB 15
`define DRM_CFG_SRC_TWO_LSB 12
`define DRM_CFG_SRC_ONE_MSB 11
`define DRM_CFG_SRC_ONE_LSB 8
`define DRM_CFG_DYN_TWO 7
`define DRM_CFG_DYN_ONE 6
`define DRM_CFG_POL_TWO 5
`define DRM_CFG_POL_ONE 4
`define DRM_CFG_FILT 3
`define DRM_CFG_IND_EN 2
`define DRM_CFG_IND_POL 1
`define DRM_CFG_IND_SEL 0

// source codes
`define DRM_SRC_OFF 4'h0
`define DRM_SRC_RATE 4'h1
`define DRM_SRC_TEMP 4'h2
`define DRM_SRC_DIAG 4'h3

// alarm bits in diagnostic_flags
`define DRM_DIAG_ALM_ONE 8
`define DRM_DIAG_ALM_TWO 9

// serial frame
`define DRM_SPI_LAST_BIT 5'd15
`define DRM_SPI_WR_BIT 15

`endif

// *** hw/drm_alarm_monitor.v ***
// How it works
// - two alarm channels, each with own threshold, window, source, mode, polarity.
// - alarm two source bits 15:12: off, coarse rate, temperature, diagnostic flags.
// - alarm one source bits 11:8 use the same source codes.
// - bit 7 / bit 6 pick dynamic (1) or static (0) mode.
// - static mode compares current source value with threshold.
// - bit 5 / bit 4: one fires above threshold, zero fires below.
// - dynamic mode compares change over window samples with threshold.
// - window bits 7:0 give sample count; 0 and 1 both mean one.
// - bit 3 selects filtered rate data; affects rate source only.
// - alarm states shown in diagnostic flag bits 9 and 8.
// - bit 2 enables indicator, bit 1 its polarity, bit 0 its line.
// - thresholds read in the same format as the selected source.
// - data ready beats alarm indicator, indicator beats general purpose control.
`include "drm_alarm_map.vh"
`timescale 1ns/1ps
`default_nettype none

module drm_alarm_monitor #(
    parameter WIN_W = 8
) (
    input wire core_clk,
    input wire rst_b,
    input wire ce,
    input wire soft_clr,
    input wire sample_strobe,
    input wire [15:0] rate_word,
    input wire [15:0] rate_filt_word,
    input wire [15:0] temp_word,
    input wire [15:0] diag_word,
    input wire drdy_en,
    input wire drdy_line_two,
    input wire drdy_level,
    input wire gpio_one_out,
    input wire gpio_one_oe,
    input wire gpio_two_out,
    input wire gpio_two_oe,
    input wire spi_cs_b,
    input wire spi_sclk,
    input wire spi_mosi,
    output reg spi_miso,
    output wire spi_miso_oe,
    output reg io_one_out,
    output reg io_one_oe,
    output reg io_two_out,
    output reg io_two_oe,
    output reg [1:0] alarm_flags,
    output reg [15:0] diag_flags
);

    localparam HIST_D = 1 << WIN_W;

    // register file
    reg [15:0] thr_one;
    reg [15:0] thr_two;
    reg [WIN_W-1:0] win_one;
    reg [WIN_W-1:0] win_two;
    reg [15:0] cfg;

    // serial link
    reg [2:0] cs_s;
    reg [2:0] sck_s;
    reg [1:0] mosi_s;
    reg [15:0] rx;
    reg [4:0] bitc;
    reg [6:0] rd_addr;
    reg [15:0] rd_data;

    // sample history, channel in the top address bit
    reg [15:0] hist [0:2*HIST_D-1];
    reg [WIN_W-1:0] ptr;

    wire cs_act = ~cs_s[1];
    wire cs_fall = cs_s[2] & ~cs_s[1];
    wire sck_rise = ~sck_s[2] & sck_s[1];
    wire sck_fall = sck_s[2] & ~sck_s[1];
    wire [15:0] rx_next = {rx[14:0], mosi_s[1]};
    wire frame_go = cs_act & sck_rise & (bitc == `DRM_SPI_LAST_BIT);
    wire wr_go = frame_go & rx_next[`DRM_SPI_WR_BIT];
    wire [6:0] wr_addr = rx_next[14:8];
    wire [7:0] wr_byte = rx_next[7:0];
    wire [6:0] wr_word = {wr_addr[6:1], 1'b0};

    assign spi_miso_oe = cs_act;

    // data source selection, rate may take the filtered word
    function [15:0] src_sel;
        input [3:0] s;
        input filt;
        input [15:0] rate;
        input [15:0] rate_f;
        input [15:0] temp;
        input [15:0] diag;
        begin
            case (s)
                `DRM_SRC_RATE: src_sel = filt ? rate_f : rate;
                `DRM_SRC_TEMP: src_sel = temp;
                `DRM_SRC_DIAG: src_sel = diag;
                default: src_sel = 16'h0000;
            endcase
        end
    endfunction

    // window length, zero counts as one sample
    function [WIN_W-1:0] win_len;
        input [WIN_W-1:0] w;
        begin
            win_len = (w == {WIN_W{1'b0}}) ? {{(WIN_W-1){1'b0}}, 1'b1} : w;
        end
    endfunction

    // one channel's comparison
    function alm_hit;
        input [3:0] s;
        input dyn;
        input pol;
        input [15:0] cur;
        input [15:0] old;
        input [15:0] thr;
        reg signed [16:0] a;
        reg signed [16:0] t;
        begin
            // flags word is unsigned, rate and temperature are twos complement
            if (s == `DRM_SRC_DIAG) begin
                a = dyn ? ({1'b0, cur} - {1'b0, old}) : {1'b0, cur};
                t = {1'b0, thr};
            end else begin
                a = dyn ? ({cur[15], cur} - {old[15], old}) : {cur[15], cur};
                t = {thr[15], thr};
            end
            if (s == `DRM_SRC_OFF || s > `DRM_SRC_DIAG)
                alm_hit = 1'b0;
            else
                alm_hit = pol ? (a > t) : (a < t);
        end
    endfunction

    wire [3:0] src_one = cfg[`DRM_CFG_SRC_ONE_MSB:`DRM_CFG_SRC_ONE_LSB];
    wire [3:0] src_two = cfg[`DRM_CFG_SRC_TWO_MSB:`DRM_CFG_SRC_TWO_LSB];
    wire [15:0] diag_view = {diag_word[15:10], alarm_flags, diag_word[7:0]};
    wire [15:0] cur_one = src_sel(src_one, cfg[`DRM_CFG_FILT], rate_word, rate_filt_word, temp_word, diag_view);
    wire [15:0] cur_two = src_sel(src_two, cfg[`DRM_CFG_FILT], rate_word, rate_filt_word, temp_word, diag_view);
    wire [WIN_W-1:0] idx_one = ptr - win_len(win_one);
    wire [WIN_W-1:0] idx_two = ptr - win_len(win_two);
    wire [15:0] old_one = hist[{1'b0, idx_one}];
    wire [15:0] old_two = hist[{1'b1, idx_two}];
    wire hit_one = alm_hit(src_one, cfg[`DRM_CFG_DYN_ONE], cfg[`DRM_CFG_POL_ONE], cur_one, old_one, thr_one);
    wire hit_two = alm_hit(src_two, cfg[`DRM_CFG_DYN_TWO], cfg[`DRM_CFG_POL_TWO], cur_two, old_two, thr_two);

    wire alm_any = |alarm_flags;
    wire alm_lvl = cfg[`DRM_CFG_IND_POL] ? alm_any : ~alm_any;
    wire ind_one = cfg[`DRM_CFG_IND_EN] & ~cfg[`DRM_CFG_IND_SEL];
    wire ind_two = cfg[`DRM_CFG_IND_EN] & cfg[`DRM_CFG_IND_SEL];

    // read mux, window registers show zero in bits 15:8
    always @* begin
        case ({rd_addr[6:1], 1'b0})
            `DRM_OFS_THR_ONE: rd_data = thr_one;
            `DRM_OFS_THR_TWO: rd_data = thr_two;
            `DRM_OFS_WIN_ONE: rd_data = {{(16-WIN_W){1'b0}}, win_one};
            `DRM_OFS_WIN_TWO: rd_data = {{(16-WIN_W){1'b0}}, win_two};
            `DRM_OFS_CFG: rd_data = cfg;
            `DRM_OFS_DIAG: rd_data = diag_flags;
            default: rd_data = 16'h0000;
        endcase
    end

    // link sampling and frame handling
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_s <= 3'h7;
            sck_s <= 3'h7;
            mosi_s <= 2'h0;
            rx <= 16'h0000;
            bitc <= 5'h00;
            rd_addr <= 7'h00;
            spi_miso <= 1'b0;
        end else if (ce) begin
            cs_s <= {cs_s[1:0], spi_cs_b};
            sck_s <= {sck_s[1:0], spi_sclk};
            mosi_s <= {mosi_s[0], spi_mosi};
            if (cs_fall) begin
                bitc <= 5'h00;
                rx <= rd_data;
                spi_miso <= rd_data[15];
            end else if (cs_act) begin
                if (sck_rise && bitc <= `DRM_SPI_LAST_BIT) begin
                    bitc <= bitc + 5'h01;
                    rx[0] <= mosi_s[1];
                    rx[15:1] <= rx[14:0];
                end
                if (sck_fall) begin
                    spi_miso <= rx[15];
                end
                if (frame_go && !rx_next[`DRM_SPI_WR_BIT]) begin
                    rd_addr <= wr_addr;
                end
            end
        end
    end

    // register writes, one byte per frame
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            thr_one <= `DRM_RST_THR;
            thr_two <= `DRM_RST_THR;
            win_one <= `DRM_RST_WIN;
            win_two <= `DRM_RST_WIN;
            cfg <= `DRM_RST_CFG;
        end else if (ce) begin
            if (soft_clr) begin
                thr_one <= `DRM_RST_THR;
                thr_two <= `DRM_RST_THR;
                win_one <= `DRM_RST_WIN;
                win_two <= `DRM_RST_WIN;
                cfg <= `DRM_RST_CFG;
            end else if (wr_go) begin
                case (wr_word)
                    `DRM_OFS_THR_ONE: begin
                        if (wr_addr[0])
                            thr_one[15:8] <= wr_byte;
                        else
                            thr_one[7:0] <= wr_byte;
                    end
                    `DRM_OFS_THR_TWO: begin
                        if (wr_addr[0])
                            thr_two[15:8] <= wr_byte;
                        else
                            thr_two[7:0] <= wr_byte;
                    end
                    `DRM_OFS_WIN_ONE: begin
                        if (!wr_addr[0])
                            win_one <= wr_byte[WIN_W-1:0];
                    end
                    `DRM_OFS_WIN_TWO: begin
                        if (!wr_addr[0])
                            win_two <= wr_byte[WIN_W-1:0];
                    end
                    `DRM_OFS_CFG: begin
                        if (wr_addr[0])
                            cfg[15:8] <= wr_byte;
                        else
                            cfg[7:0] <= wr_byte;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // history store, one entry per sample and channel
    always @(posedge core_clk) begin
        if (ce && sample_strobe) begin
            hist[{1'b0, ptr}] <= cur_one;
            hist[{1'b1, ptr}] <= cur_two;
        end
    end

    // per-sample evaluation
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr <= {WIN_W{1'b0}};
            alarm_flags <= 2'b00;
        end else if (ce) begin
            if (soft_clr) begin
                ptr <= {WIN_W{1'b0}};
                alarm_flags <= 2'b00;
            end else if (sample_strobe) begin
                ptr <= ptr + {{(WIN_W-1){1'b0}}, 1'b1};
                alarm_flags <= {hit_two, hit_one};
            end
        end
    end

    // diagnostic word and line drive
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            diag_flags <= 16'h0000;
            io_one_out <= 1'b0;
            io_one_oe <= 1'b0;
            io_two_out <= 1'b0;
            io_two_oe <= 1'b0;
        end else if (ce) begin
            diag_flags <= diag_view;
            if (drdy_en && !drdy_line_two) begin
                io_one_out <= drdy_level;
                io_one_oe <= 1'b1;
            end else if (ind_one) begin
                io_one_out <= alm_lvl;
                io_one_oe <= 1'b1;
            end else begin
                io_one_out <= gpio_one_out;
                io_one_oe <= gpio_one_oe;
            end
            if (drdy_en && drdy_line_two) begin
                io_two_out <= drdy_level;
                io_two_oe <= 1'b1;
            end else if (ind_two) begin
                io_two_out <= alm_lvl;
                io_two_oe <= 1'b1;
            end else begin
                io_two_out <= gpio_two_out;
                io_two_oe <= gpio_two_oe;
            end
        end
    end

endmodule // drm_alarm_monitor

`default_nettype wire

// *** verification/drm_alarm_monitor_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module drm_alarm_chk #(
    parameter WIN_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic soft_clr,
    input wire logic sample_strobe,
    input wire logic [15:0] diag_word,
    input wire logic drdy_en,
    input wire logic drdy_line_two,
    input wire logic drdy_level,
    input wire logic spi_cs_b,
    input wire logic spi_miso_oe,
    input wire logic io_one_out,
    input wire logic io_one_oe,
    input wire logic io_two_out,
    input wire logic io_two_oe,
    input wire logic [1:0] alarm_flags,
    input wire logic [15:0] diag_flags
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire logic run = ce && !soft_clr;
    sequence quiet; run && !sample_strobe; endsequence
    sequence cs_idle; (ce && spi_cs_b) [*4]; endsequence
    sequence cs_busy; (ce && !spi_cs_b) [*4]; endsequence
    a_flags_hold: assert property (quiet ##1 quiet |-> $stable(alarm_flags))
        else $error("flags moved without a sample");
    a_diag_mirror: assert property (run |=>
        diag_flags == (($past(diag_word) & 16'hfcff) | {6'h00, $past(alarm_flags), 8'h00}))
        else $error("diag flags do not mirror alarm flags");
    a_soft_clear: assert property (ce && soft_clr |=> alarm_flags == 2'b00)
        else $error("flags not cleared");
    a_ce_freeze: assert property (!ce |=> $stable(alarm_flags) && $stable(diag_flags) && $stable(io_one_out))
        else $error("outputs moved while frozen");
    a_drdy_one: assert property (run && drdy_en && !drdy_line_two |=> io_one_oe && io_one_out == $past(drdy_level))
        else $error("data ready lost line one");
    a_drdy_two: assert property (run && drdy_en && drdy_line_two |=> io_two_oe && io_two_out == $past(drdy_level))
        else $error("data ready lost line two");
    a_oe_off: assert property (cs_idle |-> !spi_miso_oe)
        else $error("miso driven outside frame");
    a_oe_on: assert property (cs_busy |-> spi_miso_oe)
        else $error("miso not driven in frame");
endmodule // drm_alarm_chk
bind drm_alarm_monitor drm_alarm_chk #(.WIN_W(WIN_W)) u_drm_alarm_chk (
    .core_clk(core_clk), .rst_b(rst_b), .ce(ce), .soft_clr(soft_clr), .sample_strobe(sample_strobe),
    .diag_word(diag_word), .drdy_en(drdy_en), .drdy_line_two(drdy_line_two), .drdy_level(drdy_level),
    .spi_cs_b(spi_cs_b), .spi_miso_oe(spi_miso_oe), .io_one_out(io_one_out), .io_one_oe(io_one_oe),
    .io_two_out(io_two_out), .io_two_oe(io_two_oe), .alarm_flags(alarm_flags), .diag_flags(diag_flags)
);
`default_nettype wire

// *** verification/drm_spi_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module drm_spi_host (
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    output logic spi_cs_b,
    output logic spi_sclk,
    output logic spi_mosi
);
    logic last = 1'b0;
    // a released miso shows the inverse of its last driven level
    wire logic line = spi_miso_oe ? spi_miso : ~last;
    always @(spi_miso or spi_miso_oe) if (spi_miso_oe) last = spi_miso;
    initial begin
        spi_cs_b = 1'b1;
        spi_sclk = 1'b1;
        spi_mosi = 1'b0;
    end
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        spi_cs_b = 1'b0;
        #40;
        for (int i = 15; i >= 0; i--) begin
            spi_sclk = 1'b0;
            spi_mosi = tx[i];
            #32;
            spi_sclk = 1'b1;
            rx[i] = line;
            #32;
        end
        // hold cs so the core sees the last rise before the frame ends
        #40;
        spi_cs_b = 1'b1;
        spi_mosi = ~spi_mosi;
        #60;
    endtask
    task automatic wr16(input logic [6:0] a, input logic [15:0] v);
        logic [15:0] rx;
        frame({1'b1, a, v[7:0]}, rx);
        frame({1'b1, a + 7'h01, v[15:8]}, rx);
    endtask
    task automatic rd16(input logic [6:0] a, output logic [15:0] v);
        frame({1'b0, a, 8'h00}, v);
        frame(16'h0000, v);
    endtask
endmodule // drm_spi_host
`default_nettype wire

// *** verification/drm_alarm_monitor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "drm_alarm_map.vh"
module drm_alarm_monitor_tb;
    logic core_clk = 1'b0, rst_b = 1'b0, ce = 1'b1, soft_clr = 1'b0, sample_strobe = 1'b0;
    logic drdy_en = 1'b0, drdy_line_two = 1'b0, drdy_level = 1'b0;
    logic gpio_one_out = 1'b0, gpio_one_oe = 1'b0, gpio_two_out = 1'b0, gpio_two_oe = 1'b0;
    logic [15:0] rate_word = 16'h0000, rate_filt_word = 16'h0000, temp_word = 16'h0000, diag_word = 16'h0000;
    logic [15:0] rd;
    wire spi_cs_b, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, io_one_out, io_one_oe, io_two_out, io_two_oe;
    wire [1:0] alarm_flags;
    wire [15:0] diag_flags;
    int n_fail = 0, n_compared = 0;
    // cfg, thr one, thr two, rate, filtered rate, temp, expected flags
    logic [15:0] rows [7][7] = '{
        '{16'h2110, 16'h0032, 16'h0000, 16'h0064, 16'h0000, 16'hfffb, 16'h0003},
        '{16'h2110, 16'h0032, 16'h0000, 16'h0014, 16'h0000, 16'h000a, 16'h0000},
        '{16'h0118, 16'h0032, 16'h0000, 16'h0000, 16'h0064, 16'h0000, 16'h0001},
        '{16'h3300, 16'h0800, 16'h0800, 16'h0000, 16'h0000, 16'h0000, 16'h0003},
        '{16'h0030, 16'h0000, 16'h0000, 16'h0064, 16'h0064, 16'h0064, 16'h0000},
        '{16'h4410, 16'h0000, 16'h0000, 16'h0064, 16'h0064, 16'h0064, 16'h0000},
        '{16'h1220, 16'h0000, 16'h0004, 16'h0005, 16'h0000, 16'hff9c, 16'h0003}};
    logic [6:0] rst_ofs [5] = '{`DRM_OFS_CFG, `DRM_OFS_THR_ONE, `DRM_OFS_WIN_TWO, `DRM_OFS_DIAG, 7'h30};
    logic [15:0] dyn_rate [6] = '{16'h0000, 16'h0014, 16'h0019, 16'h001e, 16'h0023, 16'h002d};
    // first delta is taken against the temperature sample of the last static row
    logic [5:0] dyn_exp = 6'b100011;
    always #2.5 core_clk = ~core_clk;
    drm_alarm_monitor u_drm_alarm_monitor (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .soft_clr(soft_clr),
        .sample_strobe(sample_strobe), .rate_word(rate_word), .rate_filt_word(rate_filt_word),
        .temp_word(temp_word), .diag_word(diag_word), .drdy_en(drdy_en), .drdy_line_two(drdy_line_two),
        .drdy_level(drdy_level), .gpio_one_out(gpio_one_out), .gpio_one_oe(gpio_one_oe),
        .gpio_two_out(gpio_two_out), .gpio_two_oe(gpio_two_oe), .spi_cs_b(spi_cs_b), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .io_one_out(io_one_out),
        .io_one_oe(io_one_oe), .io_two_out(io_two_out), .io_two_oe(io_two_oe), .alarm_flags(alarm_flags),
        .diag_flags(diag_flags));
    drm_spi_host u_drm_spi_host (.spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .spi_cs_b(spi_cs_b),
        .spi_sclk(spi_sclk), .spi_mosi(spi_mosi));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic smp(input logic [15:0] r, input logic [15:0] f, input logic [15:0] t);
        @(negedge core_clk);
        {rate_word, rate_filt_word, temp_word, diag_word} = {r, f, t, 16'h0004};
        sample_strobe = 1'b1;
        @(negedge core_clk);
        sample_strobe = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask
    task automatic cfg(input logic [15:0] c, input logic [15:0] t1, input logic [15:0] t2);
        u_drm_spi_host.wr16(`DRM_OFS_CFG, c);
        u_drm_spi_host.wr16(`DRM_OFS_THR_ONE, t1);
        u_drm_spi_host.wr16(`DRM_OFS_THR_TWO, t2);
    endtask
    task automatic end_sim;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        end_sim;
    end
    initial begin
        repeat (8) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge core_clk);
        foreach (rst_ofs[k]) begin
            u_drm_spi_host.rd16(rst_ofs[k], rd);
            chk("reset value", 16'h0000, rd);
        end
        u_drm_spi_host.wr16(`DRM_OFS_WIN_ONE, 16'hab00);
        u_drm_spi_host.rd16(`DRM_OFS_WIN_ONE, rd);
        chk("window", 16'h0000, rd);
        $display("test registers done");
        for (int i = 0; i < 7; i++) begin
            cfg(rows[i][0], rows[i][1], rows[i][2]);
            smp(rows[i][3], rows[i][4], rows[i][5]);
            chk("flags", rows[i][6], {14'h0, alarm_flags});
            chk("diag", (rows[i][6] << 8) | 16'h0004, diag_flags);
        end
        $display("test static rows done");
        cfg(16'h0150, 16'h000a, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            if (i == 3) u_drm_spi_host.wr16(`DRM_OFS_WIN_ONE, 16'h0002);
            smp(dyn_rate[i], 16'h0000, 16'h0000);
            chk("dynamic", {15'h0, dyn_exp[i]}, {14'h0, alarm_flags});
        end
        $display("test dynamic done");
        cfg(16'h0117, 16'h000a, 16'h0000);
        smp(16'h0064, 16'h0000, 16'h0000);
        chk("ind two", 16'h0003, {14'h0, io_two_oe, io_two_out});
        u_drm_spi_host.rd16(`DRM_OFS_CFG, rd);
        chk("cfg read", 16'h0117, rd);
        u_drm_spi_host.rd16(`DRM_OFS_DIAG, rd);
        chk("diag read", 16'h0104, rd);
        {drdy_en, drdy_line_two, drdy_level} = 3'b110;
        repeat (3) @(negedge core_clk);
        chk("drdy two", 16'h0002, {14'h0, io_two_oe, io_two_out});
        {drdy_en, drdy_line_two, drdy_level} = 3'b101;
        repeat (3) @(negedge core_clk);
        chk("drdy one", 16'h0003, {14'h0, io_one_oe, io_one_out});
        chk("ind two kept", 16'h0003, {14'h0, io_two_oe, io_two_out});
        {drdy_en, gpio_one_out, gpio_one_oe, gpio_two_out, gpio_two_oe} = 5'b01111;
        u_drm_spi_host.wr16(`DRM_OFS_CFG, 16'h0114);
        smp(16'h0064, 16'h0000, 16'h0000);
        chk("ind one", 16'h0002, {14'h0, io_one_oe, io_one_out});
        chk("gpio two", 16'h0003, {14'h0, io_two_oe, io_two_out});
        $display("test indicator done");
        ce = 1'b0;
        smp(16'h0000, 16'h0000, 16'h0000);
        ce = 1'b1;
        chk("frozen", 16'h0001, {14'h0, alarm_flags});
        soft_clr = 1'b1;
        @(negedge core_clk);
        soft_clr = 1'b0;
        repeat (2) @(negedge core_clk);
        chk("cleared", 16'h0000, {14'h0, alarm_flags});
        $display("test freeze and clear done");
        end_sim;
    end
endmodule // drm_alarm_monitor_tb
`default_nettype wire
